/* rtl/e1_rx_status_regs.sv */
// What this block does
// - flag tx store empty on repeated frame
// - flag rx store full on deleted frame
// - six-bit counter, bits 5..2 shown high
// - counter bit 0 shown, bit 1 hidden
// - frame search active flag is live
// - cas multiframe search active flag is live
// - crc multiframe search active flag is live
// - count each expired 8 ms search window
// - clear counter on crc multiframe sync
// - clear counter while crc mode disabled
// - counter wraps after maximum
// - carrier loss after 255 or 2048 zeros
// - digital-data carrier loss reported separately
// - sync loss flag while not synchronised
// - status bits latch, clear on mask write
// - mask write selects bits to refresh
// - search status register is live, read-only
// - alarm change drives interrupt until its bit is mask-written
`timescale 1ns/1ns
`default_nettype none
module e1_rx_status_regs
    import e1_rx_status_pkg::*;
#(
    parameter int unsigned CRC_WIN_CYCLES = CRC_WINDOW_CYCLES
)(
    input  wire logic       ref_clk_in,
    input  wire logic       sys_rst_in,
    // parallel control port pins
    input  wire logic       cs_n_in,
    input  wire logic       rd_n_in,
    input  wire logic       wr_n_in,
    input  wire logic [7:0] addr_in,
    input  wire logic [7:0] data_in,
    output logic      [7:0] data_out,
    output logic            data_oe_out,
    // line pins
    input  wire logic       line_in_positive,
    input  wire logic       line_in_negative,
    input  wire logic       rx_digital_pos_in,
    input  wire logic       rx_digital_neg_in,
    input  wire logic       rx_bit_en_in,
    // framer and elastic store events (one-cycle pulses)
    input  wire logic       tx_frame_deleted_in,
    input  wire logic       tx_frame_repeated_in,
    input  wire logic       jitter_atten_limit_trip_in,
    input  wire logic       rx_frame_deleted_in,
    input  wire logic       rx_frame_repeated_in,
    input  wire logic       crc_resync_criteria_in,
    input  wire logic       frame_align_resync_criteria_in,
    input  wire logic       mf_align_resync_criteria_in,
    input  wire logic       rx_sig_all_ones_in,
    input  wire logic       rx_distant_mf_alarm_in,
    input  wire logic       rx_sig_all_zeros_in,
    input  wire logic       rx_elastic_slip_in,
    // framer alarm and search levels
    input  wire logic       rx_unframed_ones_in,
    input  wire logic       rx_remote_alarm_in,
    input  wire logic       rx_sync_loss_in,
    input  wire logic       frame_search_active_in,
    input  wire logic       mf_search_active_in,
    input  wire logic       crc_mf_search_active_in,
    input  wire logic       crc_mf_sync_achieved_in,
    // control bits
    input  wire logic       crc_mode_enable_in,
    input  wire logic       carrier_loss_long_select_in,
    // outputs
    output logic            int_n_out,
    output logic            digital_carrier_loss_out
);
    // masked refresh of a read view, shared by both latched registers
    function automatic logic [7:0] refresh(input logic [7:0] view, input logic [7:0] live,
                                           input logic [7:0] mask);
        refresh = (live & mask) | (view & ~mask);
    endfunction
    logic [18:0] port_s1_r;          // first sync stage, read only by stage two
    logic [18:0] port_s2_r;          // second sync stage
    logic        wr_n_d_r;           // delayed write strobe for edge detect
    logic [3:0]  line_s1_r;          // line pin first stage
    logic [3:0]  line_s2_r;          // line pin second stage
    port_state_t port_state_r;
    logic [7:0]  sr1_latch_r;        // sticky alarm status
    logic [7:0]  rir_latch_r;        // sticky information status
    logic [7:0]  sr1_view_r;         // what the host reads
    logic [7:0]  rir_view_r;
    logic [7:0]  ssr_r;              // live search status
    logic [5:0]  sync_cnt_r;         // crc sync search counter
    logic [19:0] win_timer_r;        // 8 ms window timer
    logic [3:0]  alarm_prev_r;       // alarms last cycle
    logic [3:0]  int_pend_r;         // alarm changes not yet cleared by a mask write
    logic        analog_loss;
    logic        wr_pulse;
    logic        sel_sr1;
    logic        sel_rir;
    logic [7:0]  wr_data;
    logic [7:0]  sr1_set;
    logic [7:0]  rir_set;
    logic [3:0]  alarm_now;
    logic        win_expire;

    // every port pin crosses through two flops before use
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            port_s1_r <= {3'b111, 16'h0000};
            port_s2_r <= {3'b111, 16'h0000};
            line_s1_r <= '0;
            line_s2_r <= '0;
        end else begin
            port_s1_r <= {cs_n_in, rd_n_in, wr_n_in, addr_in, data_in};
            port_s2_r <= port_s1_r;
            line_s1_r <= {line_in_positive, line_in_negative, rx_digital_pos_in, rx_digital_neg_in};
            line_s2_r <= line_s1_r;
        end
    end

    // strobe edges are taken from the second stage only
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            wr_n_d_r <= 1'b1;
        end else begin
            wr_n_d_r <= port_s2_r[16];
        end
    end
    assign wr_pulse = wr_n_d_r && !port_s2_r[16] && !port_s2_r[18];
    assign wr_data  = port_s2_r[7:0];
    assign sel_sr1  = port_s2_r[15:8] == ADDR_ALARM_STATUS;
    assign sel_rir  = port_s2_r[15:8] == ADDR_INFO_STATUS;
    // port state follows the synchronised strobes
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            port_state_r <= PORT_IDLE;
        end else begin
            case (port_state_r)
                PORT_IDLE: begin
                    if (!port_s2_r[18] && !port_s2_r[17]) begin
                        port_state_r <= PORT_READ;
                    end else if (wr_pulse) begin
                        port_state_r <= PORT_WRITE;
                    end
                end
                PORT_READ: begin
                    if (port_s2_r[18] || port_s2_r[17]) begin
                        port_state_r <= PORT_IDLE;
                    end
                end
                PORT_WRITE: begin
                    if (port_s2_r[16]) begin
                        port_state_r <= PORT_IDLE;
                    end
                end
                default: port_state_r <= PORT_IDLE;
            endcase
        end
    end

    // read data: unmapped offsets read as zero; ssr needs no mask write
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            data_out    <= STATUS_RESET;
            data_oe_out <= 1'b0;
        end else begin
            data_oe_out <= port_state_r == PORT_READ;
            case (port_s2_r[15:8])
                ADDR_ALARM_STATUS:  data_out <= sr1_view_r;
                ADDR_INFO_STATUS:   data_out <= rir_view_r;
                ADDR_SEARCH_STATUS: data_out <= ssr_r;
                default:            data_out <= STATUS_RESET;
            endcase
        end
    end

    // carrier loss on the line pins and, separately, on recovered data
    carrier_loss_detect u_analog_loss (
        .ref_clk_in     (ref_clk_in),
        .sys_rst_in     (sys_rst_in),
        .bit_en_in      (rx_bit_en_in),
        .bit_zero_in    (!line_s2_r[3] && !line_s2_r[2]),
        .long_select_in (carrier_loss_long_select_in),
        .loss_out       (analog_loss)
    );
    carrier_loss_detect u_digital_loss (
        .ref_clk_in     (ref_clk_in),
        .sys_rst_in     (sys_rst_in),
        .bit_en_in      (rx_bit_en_in),
        .bit_zero_in    (!line_s2_r[1] && !line_s2_r[0]),
        .long_select_in (carrier_loss_long_select_in),
        .loss_out       (digital_carrier_loss_out)
    );
    assign alarm_now = {rx_unframed_ones_in, rx_remote_alarm_in, analog_loss, rx_sync_loss_in};
    assign sr1_set   = {rx_sig_all_ones_in, rx_distant_mf_alarm_in, rx_sig_all_zeros_in,
                        rx_elastic_slip_in, alarm_now};
    assign rir_set   = {tx_frame_deleted_in, tx_frame_repeated_in, jitter_atten_limit_trip_in,
                        rx_frame_deleted_in, rx_frame_repeated_in, crc_resync_criteria_in,
                        frame_align_resync_criteria_in, mf_align_resync_criteria_in};

    // sticky bits: a set in the clearing cycle wins; a persisting alarm re-sets
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            sr1_latch_r <= STATUS_RESET;
            rir_latch_r <= STATUS_RESET;
        end else begin
            sr1_latch_r <= sr1_set | (sr1_latch_r & ~((wr_pulse && sel_sr1) ? wr_data : 8'h00));
            rir_latch_r <= rir_set | (rir_latch_r & ~((wr_pulse && sel_rir) ? wr_data : 8'h00));
        end
    end

    // mask write refreshes only the selected bits of the read view
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            sr1_view_r <= STATUS_RESET;
            rir_view_r <= STATUS_RESET;
        end else if (wr_pulse) begin
            if (sel_sr1) begin
                sr1_view_r <= refresh(sr1_view_r, sr1_latch_r, wr_data);
            end
            if (sel_rir) begin
                rir_view_r <= refresh(rir_view_r, rir_latch_r, wr_data);
            end
        end
    end

    // 8 ms window timer runs only while the crc search is live
    assign win_expire = win_timer_r == 20'(CRC_WIN_CYCLES - 1);
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in || !crc_mf_search_active_in || !crc_mode_enable_in || win_expire) begin
            win_timer_r <= '0;
        end else begin
            win_timer_r <= win_timer_r + 20'd1;
        end
    end

    // search counter; plain 6-bit add wraps to zero by itself
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in || !crc_mode_enable_in) begin
            sync_cnt_r <= COUNT_RESET;
        end else if (crc_mf_sync_achieved_in) begin
            sync_cnt_r <= COUNT_RESET;
        end else if (win_expire) begin
            sync_cnt_r <= sync_cnt_r + 6'd1;
        end
    end

    // live synchroniser status; counter bit 1 is deliberately not shown
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            ssr_r <= STATUS_RESET;
        end else begin
            ssr_r <= {sync_cnt_r[5:2], sync_cnt_r[0], frame_search_active_in,
                      mf_search_active_in, crc_mf_search_active_in};
        end
    end

    // alarm change in either direction holds the interrupt until its bit is mask-written to the alarm status register
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            alarm_prev_r <= '0;
            int_pend_r   <= '0;
            int_n_out    <= 1'b1;
        end else begin
            alarm_prev_r <= alarm_now;
            int_pend_r   <= (alarm_now ^ alarm_prev_r) |
                            (int_pend_r & ~((wr_pulse && sel_sr1) ? wr_data[3:0] : 4'h0));
            int_n_out    <= ~|int_pend_r;
        end
    end
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    sequence s_alarm_change;
        alarm_now != alarm_prev_r;
    endsequence
    sequence s_int_low;
        ##2 !int_n_out;
    endsequence
    a_cnt_wraps: assert property (crc_mode_enable_in && !crc_mf_sync_achieved_in && win_expire
        && sync_cnt_r == 6'h3F |=> sync_cnt_r == 6'h00) else $error("counter did not wrap");
    a_cnt_increments: assert property (crc_mode_enable_in && !crc_mf_sync_achieved_in
        && win_expire |=> sync_cnt_r == $past(sync_cnt_r) + 6'd1) else $error("counter missed window");
    a_cnt_sync_clear: assert property (crc_mf_sync_achieved_in |=> sync_cnt_r == 6'h00)
        else $error("counter not cleared on sync");
    a_cnt_mode_clear: assert property (!crc_mode_enable_in |=> sync_cnt_r == 6'h00)
        else $error("counter not cleared with crc off");
    a_ssr_live_view: assert property (##1 ssr_r == {$past(sync_cnt_r[5:2]), $past(sync_cnt_r[0]),
        $past(frame_search_active_in), $past(mf_search_active_in), $past(crc_mf_search_active_in)})
        else $error("search status not live");
    a_sync_loss_sticks: assert property (rx_sync_loss_in |=> sr1_latch_r[SR_SYNC_LOSS])
        else $error("sync loss not latched");
    a_tx_empty_flag: assert property (tx_frame_repeated_in |=> rir_latch_r[IR_TX_EMPTY])
        else $error("tx empty not latched");
    a_rx_full_flag: assert property (rx_frame_deleted_in |=> rir_latch_r[IR_RX_FULL])
        else $error("rx full not latched");
    a_int_on_change: assert property (s_alarm_change |-> s_int_low)
        else $error("interrupt missed alarm change");
    a_view_mask_hold: assert property (wr_pulse && sel_sr1 && wr_data == 8'h00
        |=> $stable(sr1_view_r)) else $error("masked bits changed");
endmodule
`default_nettype wire

/* rtl/e1_rx_status_pkg.sv */
package e1_rx_status_pkg;
    // register offsets on the parallel control port
    localparam logic [7:0] ADDR_ALARM_STATUS  = 8'h06;
    localparam logic [7:0] ADDR_INFO_STATUS   = 8'h08;
    localparam logic [7:0] ADDR_SEARCH_STATUS = 8'h1E;

    // reset values
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [5:0] COUNT_RESET  = 6'h00;

    // field positions in the alarm status register
    localparam int unsigned SR_SYNC_LOSS    = 0;
    localparam int unsigned SR_CARRIER_LOSS = 1;

    // field positions in the information register
    localparam int unsigned IR_TX_FULL  = 7;
    localparam int unsigned IR_TX_EMPTY = 6;
    localparam int unsigned IR_RX_FULL  = 4;
    localparam int unsigned IR_RX_EMPTY = 3;

    // carrier loss thresholds in bit times
    localparam logic [11:0] CL_ZEROS_SHORT = 12'd255;
    localparam logic [11:0] CL_ZEROS_LONG  = 12'd2048;
    localparam logic [7:0]  CL_WINDOW_BITS = 8'd255;
    localparam logic [5:0]  CL_ONES_CLEAR  = 6'd32;

    // timing: the crc multiframe search window
    localparam int unsigned CLK_PERIOD_NS     = 8;
    localparam int unsigned CRC_WINDOW_NS     = 8_000_000;
    localparam int unsigned CRC_WINDOW_CYCLES = CRC_WINDOW_NS / CLK_PERIOD_NS;
    localparam int unsigned HOST_GIVE_UP_MS   = 400;

    // port strobe decoder states
    typedef enum logic [1:0] {
        PORT_IDLE  = 2'b00,
        PORT_READ  = 2'b01,
        PORT_WRITE = 2'b10
    } port_state_t;
endpackage

/* rtl/carrier_loss_detect.sv */
`timescale 1ns/1ns
`default_nettype none
module carrier_loss_detect
    import e1_rx_status_pkg::*;
(
    input  wire logic ref_clk_in,
    input  wire logic sys_rst_in,
    input  wire logic bit_en_in,        // one bit time
    input  wire logic bit_zero_in,      // both rails quiet this bit
    input  wire logic long_select_in,   // 2048 zero threshold
    output logic      loss_out
);
    logic [11:0] zero_run_r;   // consecutive zeros, saturating
    logic [7:0]  win_cnt_r;    // bit times within clear window
    logic [5:0]  ones_cnt_r;   // ones seen within clear window
    logic [11:0] thresh;

    assign thresh = long_select_in ? CL_ZEROS_LONG : CL_ZEROS_SHORT;

    // zero run counter; saturates so long outages do not wrap back
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            zero_run_r <= '0;
        end else if (bit_en_in) begin
            if (!bit_zero_in) begin
                zero_run_r <= '0;
            end else if (zero_run_r != 12'hFFF) begin
                zero_run_r <= zero_run_r + 12'd1;
            end
        end
    end

    // clear window: 32 ones inside 255 bit times ends the loss
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in || !loss_out) begin
            win_cnt_r  <= '0;
            ones_cnt_r <= '0;
        end else if (bit_en_in) begin
            if (win_cnt_r == CL_WINDOW_BITS - 8'd1) begin
                win_cnt_r  <= '0;
                ones_cnt_r <= '0;
            end else begin
                win_cnt_r  <= win_cnt_r + 8'd1;
                ones_cnt_r <= ones_cnt_r + {5'd0, !bit_zero_in};
            end
        end
    end

    // loss flag
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            loss_out <= 1'b0;
        end else if (!loss_out && zero_run_r >= thresh) begin
            loss_out <= 1'b1;
        end else if (loss_out && ones_cnt_r >= CL_ONES_CLEAR) begin
            loss_out <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* verif/host_port_model.sv */
`timescale 1ns/1ns
`default_nettype none
// host processor on the parallel control port
module host_port_model (
    input  wire logic       clk_in,
    input  wire logic [7:0] rdata_in,
    input  wire logic       oe_in,
    output logic            cs_n_out,
    output logic            rd_n_out,
    output logic            wr_n_out,
    output logic      [7:0] addr_out,
    output logic      [7:0] wdata_out
);
    // idle: strobes high, bus holds junk
    initial begin
        cs_n_out = 1'b1;
        rd_n_out = 1'b1;
        wr_n_out = 1'b1;
        addr_out = 8'h00;
        wdata_out = 8'hA5;
    end
    // mask byte ahead of a latched read
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_out <= a;
        wdata_out <= d;
        cs_n_out <= 1'b0;
        wr_n_out <= 1'b0;
        repeat (4) @(posedge clk_in);
        cs_n_out <= 1'b1;
        wr_n_out <= 1'b1;
        addr_out <= ~a; // released bus must not show stale values
        wdata_out <= ~d;
        repeat (3) @(posedge clk_in);
    endtask
    // read: strobes held until output enable is seen, bounded
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
        int n;
        ok = 1'b0;
        d = 8'h00;
        @(posedge clk_in);
        addr_out <= a;
        cs_n_out <= 1'b0;
        rd_n_out <= 1'b0;
        for (n = 0; n < 20 && !ok; n++) begin
            @(posedge clk_in);
            if (oe_in === 1'b1) begin
                ok = 1'b1;
                d = rdata_in;
            end
        end
        cs_n_out <= 1'b1;
        rd_n_out <= 1'b1;
        addr_out <= ~a;
        repeat (4) @(posedge clk_in);
    endtask
endmodule
`default_nettype wire

/* verif/e1_rx_status_regs_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module e1_rx_status_regs_bench;
    import e1_rx_status_pkg::*;
    localparam int unsigned WIN = 16; // short search window keeps the run brief
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cs_n, rd_n, wr_n, oe, int_n, dcl;
    logic [7:0]  addr, wdata, rdata, v;
    logic        lp = 1'b1, ln = 1'b0, bit_en = 1'b0, sync_ok = 1'b0;
    logic        crc_en = 1'b0, long_sel = 1'b0, ok;
    logic [11:0] ev = '0;   // info events 7..0 then alarm events 7..4
    logic [2:0]  lvl = '0;  // unframed ones, remote alarm, sync loss
    logic [2:0]  srch = '0; // frame, mf, crc search levels
    int          errors = 0;
    int          check_count = 0;
    always #4 clk = ~clk;
    host_port_model host (.clk_in(clk), .rdata_in(rdata), .oe_in(oe), .cs_n_out(cs_n),
        .rd_n_out(rd_n), .wr_n_out(wr_n), .addr_out(addr), .wdata_out(wdata));
    e1_rx_status_regs #(.CRC_WIN_CYCLES(WIN)) dut (.ref_clk_in(clk), .sys_rst_in(rst),
        .cs_n_in(cs_n), .rd_n_in(rd_n), .wr_n_in(wr_n), .addr_in(addr), .data_in(wdata),
        .data_out(rdata), .data_oe_out(oe), .line_in_positive(lp), .line_in_negative(ln),
        .rx_digital_pos_in(lp), .rx_digital_neg_in(ln), .rx_bit_en_in(bit_en),
        .tx_frame_deleted_in(ev[11]), .tx_frame_repeated_in(ev[10]),
        .jitter_atten_limit_trip_in(ev[9]), .rx_frame_deleted_in(ev[8]),
        .rx_frame_repeated_in(ev[7]), .crc_resync_criteria_in(ev[6]),
        .frame_align_resync_criteria_in(ev[5]), .mf_align_resync_criteria_in(ev[4]),
        .rx_sig_all_ones_in(ev[3]), .rx_distant_mf_alarm_in(ev[2]),
        .rx_sig_all_zeros_in(ev[1]), .rx_elastic_slip_in(ev[0]),
        .rx_unframed_ones_in(lvl[2]), .rx_remote_alarm_in(lvl[1]), .rx_sync_loss_in(lvl[0]),
        .frame_search_active_in(srch[2]), .mf_search_active_in(srch[1]),
        .crc_mf_search_active_in(srch[0]), .crc_mf_sync_achieved_in(sync_ok),
        .crc_mode_enable_in(crc_en), .carrier_loss_long_select_in(long_sel),
        .int_n_out(int_n), .digital_carrier_loss_out(dcl));
    // verdict and end of run
    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", name, exp, got);
            errors++;
        end
    endtask
    // read; a host that never sees output enable ends the run
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
        host.read_reg(a, v, ok);
        if (ok !== 1'b1) begin
            errors++;
            finish_test();
        end
        chk(name, exp, v);
    endtask
    // mask write then read of a latched register
    task automatic peek(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
        host.write_reg(a, m);
        rd(a, exp, "latched view");
    endtask
    // bounded wait for the interrupt pin level
    task automatic wait_int(input logic lev);
        int n;
        for (n = 0; n < 12 && int_n !== lev; n++) @(posedge clk);
        chk("int_n", {7'h00, lev}, {7'h00, int_n});
    endtask
    task automatic t_reset();
        peek(ADDR_ALARM_STATUS, 8'hFF, 8'h00);
        peek(ADDR_INFO_STATUS, 8'hFF, 8'h00);
        rd(ADDR_SEARCH_STATUS, 8'h00, "search");
        rd(8'h55, 8'h00, "unmapped");
        wait_int(1'b1);
    endtask
    // every event latches its own bit and raises no interrupt
    task automatic t_events();
        int i;
        logic [7:0] m;
        for (i = 0; i < 12; i++) begin
            m = 8'h01 << ((i >= 4) ? i - 4 : i + 4);
            @(posedge clk) ev[i] <= 1'b1;
            @(posedge clk) ev[i] <= 1'b0;
            peek((i >= 4) ? ADDR_INFO_STATUS : ADDR_ALARM_STATUS, m, m);
            peek((i >= 4) ? ADDR_INFO_STATUS : ADDR_ALARM_STATUS, m, 8'h00);
            wait_int(1'b1);
        end
    endtask
    // a zero mask bit keeps the previous view
    task automatic t_mask();
        @(posedge clk) ev[10] <= 1'b1;
        @(posedge clk) ev[10] <= 1'b0;
        peek(ADDR_INFO_STATUS, 8'h40, 8'h40);
        peek(ADDR_INFO_STATUS, 8'h00, 8'h40);
        peek(ADDR_INFO_STATUS, 8'h40, 8'h00);
    endtask
    // alarm levels interrupt on both edges and stay set while present
    task automatic t_alarms();
        int k;
        logic [7:0] m;
        for (k = 0; k < 3; k++) begin
            m = 8'h01 << ((k == 0) ? 0 : k + 1);
            @(posedge clk) lvl[k] <= 1'b1;
            wait_int(1'b0);
            peek(ADDR_ALARM_STATUS, m, m);
            wait_int(1'b1);
            peek(ADDR_ALARM_STATUS, m, m);
            peek(ADDR_ALARM_STATUS, 8'h00, m);
            @(posedge clk) lvl[k] <= 1'b0;
            wait_int(1'b0);
            peek(ADDR_ALARM_STATUS, m, m);
            peek(ADDR_ALARM_STATUS, m, 8'h00);
            wait_int(1'b1);
        end
    endtask
    // search flags live, register not writable
    task automatic t_search();
        @(posedge clk) srch <= 3'b110;
        repeat (4) @(posedge clk);
        rd(ADDR_SEARCH_STATUS, 8'h06, "search");
        host.write_reg(ADDR_SEARCH_STATUS, 8'hFF);
        @(posedge clk) srch <= 3'b001;
        repeat (4) @(posedge clk);
        rd(ADDR_SEARCH_STATUS, 8'h01, "search");
        @(posedge clk) srch <= 3'b000;
    endtask
    // search window expiries, crc mode on
    task automatic search_for(input int wins);
        @(posedge clk) srch <= 3'b001;
        repeat (wins * WIN + 4) @(posedge clk);
        srch <= 3'b000;
        repeat (3) @(posedge clk);
    endtask
    // host would give up after 400 ms; the counter only reports elapsed windows
    task automatic t_counter();
        @(posedge clk) crc_en <= 1'b1;
        search_for(5);
        rd(ADDR_SEARCH_STATUS, 8'h18, "count");
        @(posedge clk) sync_ok <= 1'b1;
        @(posedge clk) sync_ok <= 1'b0;
        rd(ADDR_SEARCH_STATUS, 8'h00, "count");
        search_for(2);
        rd(ADDR_SEARCH_STATUS, 8'h00, "count");
        search_for(1);
        rd(ADDR_SEARCH_STATUS, 8'h08, "count");
        @(posedge clk) crc_en <= 1'b0;
        repeat (4) @(posedge clk);
        rd(ADDR_SEARCH_STATUS, 8'h00, "count");
        @(posedge clk) crc_en <= 1'b1;
        search_for(65);
        rd(ADDR_SEARCH_STATUS, 8'h08, "count");
    endtask
    // n line bits of one polarity; rails settle before the bit strobe
    task automatic bits(input logic p, input int n);
        repeat (n) begin
            @(posedge clk) lp <= p;
            repeat (3) @(posedge clk);
            bit_en <= 1'b1;
            @(posedge clk) bit_en <= 1'b0;
        end
    endtask
    task automatic t_carrier(input logic sel, input int thr);
        @(posedge clk) long_sel <= sel;
        bits(1'b0, thr - 1);
        peek(ADDR_ALARM_STATUS, 8'h02, 8'h00);
        bits(1'b0, 1);
        repeat (4) @(posedge clk);
        peek(ADDR_ALARM_STATUS, 8'h02, 8'h02);
        chk("digital loss", 8'h01, {7'h00, dcl});
        bits(1'b1, 40);
        peek(ADDR_ALARM_STATUS, 8'h02, 8'h02);
        peek(ADDR_ALARM_STATUS, 8'h02, 8'h00);
        chk("digital loss", 8'h00, {7'h00, dcl});
        wait_int(1'b1);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        t_reset();
        t_events();
        t_mask();
        t_alarms();
        t_search();
        t_counter();
        t_carrier(1'b0, 255);
        t_carrier(1'b1, 2048);
        finish_test();
    end
endmodule
`default_nettype wire
